// ---- fbc_pkg.sv ----
/*
 Constants, field layout, operation codes and state codes for the flash
 bank command controller. Assumes a 40 MHz core clock and a flash that
 keeps the customary unlock and reset command codes.
*/
// How it works
// RULE1: Each bank reads array after power-up and after an embedded algorithm ends.
// RULE2: Erase suspend gives suspend-read; suspended sectors return status data.
// RULE3: Host writes reset after timeout bit rises, or to leave identification mode.
// RULE4: Reset returns banks to read or suspend-read; its address is ignored.
// RULE5: Reset between erase cycles aborts; once erasing, resets are ignored.
// RULE6: Reset between program cycles aborts; once programming, resets are ignored.
// RULE7: Aborted program in a suspended bank returns it to suspend-read.
// RULE8: Reset allowed mid identification sequence; only reset leaves identification mode.
// RULE9: Reset after timeout bit returns to read or suspend-read mode.
// RULE10: Identification sequence only to an idle bank, never while another programs.
// RULE11: Identification entry: two unlocks, then bank address with command; reads repeat.
// RULE12: Protection query reads carry bank address and sector select address.
// RULE13: Three writes enter the secured region; four writes leave it.
// RULE14: Secured region holds an eight word random serial number.
// RULE15: Secured region unreachable while busy; bypass and acceleration unavailable there.
// RULE16: Word program is two unlocks, setup, then address and data.
// RULE17: After program the bank reads array; progress shows on poll, toggle, busy.
// RULE18: Commands during embedded program are ignored; hardware reset stops it.
// RULE19: Programming only clears bits; a one over zero stays zero.
// RULE20: Two unlocks and 20h enter bypass; each word is A0h then data.
// RULE21: Bypass accepts only bypass program and bypass reset; exits by two writes.
// RULE22: High voltage on the accelerate pin enters bypass; only while programming.
// Code holds it high while the control bit is set outside identification mode, even when idle.
// RULE23: Unlocks are AAh at 555h, 55h at 2AAh; reset data is F0h.
// RULE24: Bad or misordered writes may confuse the device; reset restores reads.
package fbc_pkg;
	localparam int AW = 23;
	localparam int DW = 16;
	localparam int RW = 8;
	localparam int OPW = 4;
	localparam int CW = 4;
	// Own register offsets
	localparam logic [RW-1:0] REG_CMD   = 8'h00;
	localparam logic [RW-1:0] REG_ADDR  = 8'h04;
	localparam logic [RW-1:0] REG_WDATA = 8'h08;
	localparam logic [RW-1:0] REG_STAT  = 8'h0C;
	localparam logic [RW-1:0] REG_RDATA = 8'h10;
	localparam logic [RW-1:0] REG_CTRL  = 8'h14;
	// Status and control bit positions
	localparam int ST_BUSY  = 0;
	localparam int ST_DONE  = 1;
	localparam int ST_TOUT  = 2;
	localparam int ST_VERR  = 3;
	localparam int ST_REFU  = 4;
	localparam int ST_ID    = 5;
	localparam int ST_SEC   = 6;
	localparam int ST_BYP   = 7;
	localparam int ST_RDY   = 8;
	localparam int ST_ACC   = 9;
	localparam int CT_ACCEL = 0;
	// Flash data bits watched while polling
	localparam int TOGGLE_BIT  = 6;
	localparam int TIMEOUT_BIT = 5;
	// Command codes
	localparam logic [AW-1:0] UNL1_ADDR = 23'h000555;
	localparam logic [AW-1:0] UNL2_ADDR = 23'h0002AA;
	localparam logic [AW-1:0] ADDR_ANY  = 23'h000000;
	localparam logic [DW-1:0] UNL1_DATA = 16'h00AA;
	localparam logic [DW-1:0] UNL2_DATA = 16'h0055;
	localparam logic [DW-1:0] CMD_RESET = 16'h00F0;
	localparam logic [DW-1:0] CMD_IDENT = 16'h0090;
	localparam logic [DW-1:0] CMD_SECIN = 16'h0088;
	localparam logic [DW-1:0] CMD_TAIL  = 16'h0000;
	localparam logic [DW-1:0] CMD_PROG  = 16'h00A0;
	localparam logic [DW-1:0] CMD_BYPIN = 16'h0020;
	// Bus timing
	localparam int CLK_NS   = 25;
	localparam int T_WP_NS  = 35;
	localparam int T_WPH_NS = 20;
	localparam int T_ACC_NS = 70;
	localparam int SYNC_CYC = 2;
	localparam logic [CW-1:0] WP_CYC  = CW'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] WPH_CYC = CW'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CW-1:0] ACC_CYC = CW'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
	typedef enum logic [OPW-1:0] {
		OP_READ      = 4'h0,
		OP_RESET     = 4'h1,
		OP_ID_ENTER  = 4'h2,
		OP_SEC_ENTER = 4'h3,
		OP_SEC_EXIT  = 4'h4,
		OP_PROGRAM   = 4'h5,
		OP_BYP_ENTER = 4'h6,
		OP_BYP_PROG  = 4'h7,
		OP_BYP_RESET = 4'h8
	} fbc_op_type;
	typedef enum logic [1:0] {
		ENG_IDLE  = 2'b00,
		ENG_PULSE = 2'b01,
		ENG_HOLD  = 2'b10
	} fbc_eng_type;
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_ISSUE = 3'b001,
		S_WAIT  = 3'b010,
		S_POLL  = 3'b011,
		S_PWAIT = 3'b100,
		S_READ  = 3'b101,
		S_RWAIT = 3'b110
	} fbc_state_type;
endpackage

// ---- fbc_cyc_if.sv ----
/*
 Bus cycle request channel between the sequencer and the pin engine.
 Assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
interface fbc_cyc_if;
	logic                 req;
	logic                 wr;
	logic [fbc_pkg::AW-1:0] addr;
	logic [fbc_pkg::DW-1:0] wdata;
	logic                 done;
	logic [fbc_pkg::DW-1:0] rdata;
	modport ctl (output req, output wr, output addr, output wdata, input done, input rdata);
	modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ---- fbc_engine.sv ----
/*
 Pin engine: runs one asynchronous flash read or write cycle per request.
 Assumes the flash data pins are resolved by the bench from dq_oe.
*/
`timescale 1ns/1ps
module fbc_engine (
	input  wire logic                   core_clk,
	input  wire logic                   arst_n,
	fbc_cyc_if.eng                      cyc,
	output logic [fbc_pkg::AW-1:0]      flash_addr,
	output logic [fbc_pkg::DW-1:0]      flash_dq_out,
	output logic                        flash_dq_oe,
	input  wire logic [fbc_pkg::DW-1:0] flash_dq_in,
	output logic                        flash_ce_n,
	output logic                        flash_we_n,
	output logic                        flash_oe_n
);
	import fbc_pkg::*;
	fbc_eng_type   state_r;
	logic [CW-1:0] cnt_r;
	logic          wr_r;
	logic [DW-1:0] dq_s1_r;
	logic [DW-1:0] dq_s2_r;

	// Two-flop synchroniser for the data pins
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dq_s1_r <= '0;
			dq_s2_r <= '0;
		end
		else
		begin
			dq_s1_r <= flash_dq_in;
			dq_s2_r <= dq_s1_r;
		end
	end

	// Cycle sequencing: address and strobes, pulse, then hold
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r      <= ENG_IDLE;
			cnt_r        <= '0;
			wr_r         <= 1'b0;
			flash_addr   <= '0;
			flash_dq_out <= '0;
			flash_dq_oe  <= 1'b0;
			flash_ce_n   <= 1'b1;
			flash_we_n   <= 1'b1;
			flash_oe_n   <= 1'b1;
			cyc.done     <= 1'b0;
			cyc.rdata    <= '0;
		end
		else
		begin
			cyc.done <= 1'b0;
			case (state_r)
				ENG_IDLE:
				begin
					if (cyc.req)
					begin
						flash_addr   <= cyc.addr;
						flash_dq_out <= cyc.wdata;
						wr_r         <= cyc.wr;
						flash_ce_n   <= 1'b0;
						flash_we_n   <= ~cyc.wr;
						flash_oe_n   <= cyc.wr;
						flash_dq_oe  <= cyc.wr; // Drive only on writes
						cnt_r        <= cyc.wr ? WP_CYC : ACC_CYC;
						state_r      <= ENG_PULSE;
					end
				end
				ENG_PULSE:
				begin
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else
					begin
						flash_we_n <= 1'b1; // Data latched on this rising edge
						flash_oe_n <= 1'b1;
						if (!wr_r)
							cyc.rdata <= dq_s2_r;
						cnt_r   <= WPH_CYC;
						state_r <= ENG_HOLD;
					end
				end
				ENG_HOLD:
				begin
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else
					begin
						flash_ce_n  <= 1'b1;
						flash_dq_oe <= 1'b0;
						cyc.done    <= 1'b1;
						state_r     <= ENG_IDLE;
					end
				end
				default:
					state_r <= ENG_IDLE;
			endcase
		end
	end
endmodule

// ---- fbc_top.sv ----
/*
 Flash bank command controller: an AHB-Lite register slave that turns
 software orders into flash command sequences and polls for completion.
 Assumes one AHB master with single word transfers and one flash bank
 being addressed at a time.
*/
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module fbc_top #(
	parameter logic [fbc_pkg::AW-1:0] BANK_MASK = 23'h600000
) (
	input  wire logic                   core_clk,
	input  wire logic                   arst_n,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	output logic [fbc_pkg::AW-1:0]      flash_addr,
	output logic [fbc_pkg::DW-1:0]      flash_dq_out,
	output logic                        flash_dq_oe,
	input  wire logic [fbc_pkg::DW-1:0] flash_dq_in,
	output logic                        flash_ce_n,
	output logic                        flash_we_n,
	output logic                        flash_oe_n,
	input  wire logic                   ready_busy_n,
	output logic                        protect_accel_pin
);
	import fbc_pkg::*;
	fbc_cyc_if     cyc ();
	fbc_state_type state_r;
	fbc_op_type    op_r;
	logic [2:0]    step_r;
	logic          second_r;
	logic [DW-1:0] prev_r;
	logic [AW-1:0] addr_r;
	logic [DW-1:0] wdata_r;
	logic [DW-1:0] rdata_r;
	logic          accel_r;
	logic          busy_r;
	logic          done_r;
	logic          tout_r;
	logic          verr_r;
	logic          refu_r;
	logic          id_r;
	logic          sec_r;
	logic          byp_r;
	logic          rdy_s1_r;
	logic          rdy_s2_r;
	logic          aph_wr_r;
	logic          aph_rd_r;
	logic [RW-1:0] aph_addr_r;
	logic          aph_hit_r;
	logic          cmd_wr;
	logic          cmd_ok;
	logic [31:0]   rd_val;
	logic [31:0]   stat_val;

	// Number of flash writes in each operation
	function automatic logic [2:0] seq_len(fbc_op_type op);
		case (op)
			OP_RESET:     seq_len = 3'd1;
			OP_ID_ENTER:  seq_len = 3'd3;
			OP_SEC_ENTER: seq_len = 3'd3;
			OP_SEC_EXIT:  seq_len = 3'd4;
			OP_PROGRAM:   seq_len = 3'd4;
			OP_BYP_ENTER: seq_len = 3'd3;
			OP_BYP_PROG:  seq_len = 3'd2;
			OP_BYP_RESET: seq_len = 3'd2;
			default:      seq_len = 3'd0;
		endcase
	endfunction

	// Address and data of write number idx of an operation
	function automatic logic [AW+DW-1:0] seq_word(fbc_op_type op, logic [2:0] idx,
		logic [AW-1:0] a, logic [DW-1:0] d);
		logic [AW-1:0] ca;
		logic [DW-1:0] third;
		ca    = (a & BANK_MASK) | UNL1_ADDR; // Bank address on command write
		third = CMD_IDENT;
		case (op)
			OP_SEC_ENTER: third = CMD_SECIN;
			OP_PROGRAM:   third = CMD_PROG;
			OP_BYP_ENTER: third = CMD_BYPIN;
			default:      third = CMD_IDENT;
		endcase
		case (op)
			OP_RESET:
				seq_word = {ADDR_ANY, CMD_RESET}; // see RULE4 see RULE23
			OP_BYP_PROG:
				seq_word = (idx == 3'd0) ? {ca, CMD_PROG} : {a, d}; // see RULE20
			OP_BYP_RESET:
				seq_word = (idx == 3'd0) ? {ca, CMD_IDENT} : {ca, CMD_TAIL}; // see RULE21
			default:
			begin
				case (idx)
					3'd0:    seq_word = {UNL1_ADDR, UNL1_DATA}; // see RULE23
					3'd1:    seq_word = {UNL2_ADDR, UNL2_DATA};
					3'd2:    seq_word = {ca, third}; // see RULE11 see RULE13 see RULE16
					default: seq_word = (op == OP_PROGRAM) ? {a, d} : {ca, CMD_TAIL};
				endcase
			end
		endcase
	endfunction

	// Whether an operation may be issued in the current mode
	function automatic logic op_legal(logic [OPW-1:0] op, logic id, logic sec, logic byp);
		op_legal = 1'b1;
		if (op > OP_BYP_RESET)
			op_legal = 1'b0;
		else if (byp)
			op_legal = (op == OP_BYP_PROG) || (op == OP_BYP_RESET) || (op == OP_READ); // see RULE21
		else if (op == OP_BYP_PROG || op == OP_BYP_RESET)
			op_legal = 1'b0;
		else if (id)
			op_legal = (op == OP_READ) || (op == OP_RESET); // see RULE8 see RULE3
		else if (sec && op == OP_BYP_ENTER)
			op_legal = 1'b0; // see RULE15
	endfunction

	// Ready/busy pin synchroniser
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdy_s1_r <= 1'b1;
			rdy_s2_r <= 1'b1;
		end
		else
		begin
			rdy_s1_r <= ready_busy_n;
			rdy_s2_r <= rdy_s1_r; // see RULE17
		end
	end

	// AHB-Lite address phase capture, read wait state and read data
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aph_wr_r   <= 1'b0;
			aph_rd_r   <= 1'b0;
			aph_addr_r <= '0;
			aph_hit_r  <= 1'b0;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			hrdata     <= '0;
		end
		else
		begin
			hresp <= 1'b0; // Always OKAY
			if (hready)
			begin
				aph_wr_r   <= hsel && htrans[1] && hwrite;
				aph_rd_r   <= hsel && htrans[1] && !hwrite;
				aph_addr_r <= haddr[RW-1:0];
				aph_hit_r  <= (haddr[31:RW] == '0);
				if (hsel && htrans[1] && !hwrite)
					hreadyout <= 1'b0; // One wait state on reads
			end
			else
			begin
				aph_wr_r <= 1'b0;
			end
			if (aph_rd_r && !hreadyout)
			begin
				hrdata    <= rd_val;
				hreadyout <= 1'b1;
				aph_rd_r  <= 1'b0;
			end
		end
	end

	// Software-written address, data and control registers
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			addr_r  <= '0;
			wdata_r <= '0;
			accel_r <= 1'b0;
		end
		else
		begin
			if (aph_wr_r && aph_hit_r && aph_addr_r == REG_ADDR)
				addr_r <= hwdata[AW-1:0]; // see RULE12
			if (aph_wr_r && aph_hit_r && aph_addr_r == REG_WDATA)
				wdata_r <= hwdata[DW-1:0];
			if (aph_wr_r && aph_hit_r && aph_addr_r == REG_CTRL)
				accel_r <= hwdata[CT_ACCEL] && !sec_r; // see RULE15
			else if (sec_r)
				accel_r <= 1'b0;
		end
	end

	// High voltage only while bypass programming may follow
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			protect_accel_pin <= 1'b0;
		else
			protect_accel_pin <= accel_r && !sec_r && !id_r; // see RULE22
	end

	// Command acceptance
	assign cmd_wr = aph_wr_r && aph_hit_r && (aph_addr_r == REG_CMD);
	assign cmd_ok = cmd_wr && (state_r == S_IDLE) && // see RULE10
		op_legal(hwdata[OPW-1:0], id_r, sec_r, byp_r || accel_r);

	// Status word
	always_comb
	begin
		stat_val = '0;
		stat_val[ST_BUSY] = busy_r;
		stat_val[ST_DONE] = done_r;
		stat_val[ST_TOUT] = tout_r;
		stat_val[ST_VERR] = verr_r;
		stat_val[ST_REFU] = refu_r;
		stat_val[ST_ID]   = id_r;
		stat_val[ST_SEC]  = sec_r;
		stat_val[ST_BYP]  = byp_r || accel_r;
		stat_val[ST_RDY]  = rdy_s2_r;
		stat_val[ST_ACC]  = accel_r;
	end

	// Register read decode; unmapped reads give zero
	always_comb
	begin
		rd_val = '0;
		if (aph_hit_r)
		begin
			case (aph_addr_r)
				REG_CMD:   rd_val[OPW-1:0] = op_r;
				REG_ADDR:  rd_val[AW-1:0] = addr_r;
				REG_WDATA: rd_val[DW-1:0] = wdata_r;
				REG_STAT:  rd_val = stat_val;
				REG_RDATA: rd_val[DW-1:0] = rdata_r;
				REG_CTRL:  rd_val[CT_ACCEL] = accel_r;
				default:   rd_val = '0;
			endcase
		end
	end

	// Sequencer: command writes, completion polling and recovery
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r   <= S_IDLE;
			op_r      <= OP_READ;
			step_r    <= '0;
			second_r  <= 1'b0;
			prev_r    <= '0;
			rdata_r   <= '0;
			busy_r    <= 1'b0;
			done_r    <= 1'b0;
			tout_r    <= 1'b0;
			verr_r    <= 1'b0;
			refu_r    <= 1'b0;
			id_r      <= 1'b0; // see RULE1
			sec_r     <= 1'b0;
			byp_r     <= 1'b0;
			cyc.req   <= 1'b0;
			cyc.wr    <= 1'b0;
			cyc.addr  <= '0;
			cyc.wdata <= '0;
		end
		else
		begin
			cyc.req <= 1'b0;
			case (state_r)
				S_IDLE:
				begin
					if (cmd_ok)
					begin
						op_r    <= fbc_op_type'(hwdata[OPW-1:0]);
						step_r  <= '0;
						busy_r  <= 1'b1;
						done_r  <= 1'b0;
						tout_r  <= 1'b0;
						verr_r  <= 1'b0;
						refu_r  <= 1'b0;
						state_r <= S_ISSUE;
					end
					else if (cmd_wr)
						refu_r <= 1'b1;
				end
				S_ISSUE:
				begin
					if (step_r < seq_len(op_r))
					begin
						cyc.req <= 1'b1;
						cyc.wr  <= 1'b1;
						{cyc.addr, cyc.wdata} <= seq_word(op_r, step_r, addr_r, wdata_r);
						step_r  <= step_r + 3'd1;
						state_r <= S_WAIT;
					end
					else if (op_r == OP_PROGRAM || op_r == OP_BYP_PROG)
					begin
						second_r <= 1'b0;
						state_r  <= S_POLL; // see RULE16 see RULE18
					end
					else if (op_r == OP_READ)
						state_r <= S_READ; // see RULE11 see RULE14
					else
					begin
						busy_r  <= 1'b0;
						done_r  <= 1'b1;
						state_r <= S_IDLE;
						case (op_r)
							OP_RESET:
							begin
								id_r <= 1'b0; // see RULE8 see RULE24
								if (tout_r)
									byp_r <= 1'b0; // see RULE9
							end
							OP_ID_ENTER:  id_r  <= 1'b1; // see RULE10
							OP_SEC_ENTER: sec_r <= 1'b1; // see RULE13
							OP_SEC_EXIT:  sec_r <= 1'b0;
							OP_BYP_ENTER: byp_r <= 1'b1; // see RULE20
							OP_BYP_RESET: byp_r <= 1'b0; // see RULE21
							default:      id_r  <= id_r;
						endcase
					end
				end
				S_WAIT:
				begin
					if (cyc.done)
						state_r <= S_ISSUE;
				end
				S_POLL:
				begin
					cyc.req  <= 1'b1;
					cyc.wr   <= 1'b0;
					cyc.addr <= addr_r;
					state_r  <= S_PWAIT;
				end
				S_PWAIT:
				begin
					if (cyc.done && !second_r)
					begin
						prev_r   <= cyc.rdata;
						second_r <= 1'b1;
						state_r  <= S_POLL;
					end
					else if (cyc.done)
					begin
						second_r <= 1'b0;
						if (prev_r[TOGGLE_BIT] == cyc.rdata[TOGGLE_BIT])
						begin
							rdata_r <= cyc.rdata;
							verr_r  <= (cyc.rdata != wdata_r); // see RULE19
							busy_r  <= 1'b0;
							done_r  <= 1'b1; // see RULE17
							state_r <= S_IDLE;
						end
						else if (cyc.rdata[TIMEOUT_BIT])
						begin
							tout_r  <= 1'b1;
							op_r    <= OP_RESET; // see RULE3
							step_r  <= '0;
							state_r <= S_ISSUE;
						end
						else
							state_r <= S_POLL;
					end
				end
				S_READ:
				begin
					cyc.req  <= 1'b1;
					cyc.wr   <= 1'b0;
					cyc.addr <= addr_r;
					state_r  <= S_RWAIT;
				end
				S_RWAIT:
				begin
					if (cyc.done)
					begin
						rdata_r <= cyc.rdata; // see RULE2 see RULE12
						busy_r  <= 1'b0;
						done_r  <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				default:
					state_r <= S_IDLE;
			endcase
		end
	end

	// Flash pin engine
	fbc_engine u_engine (
		.core_clk     (core_clk),
		.arst_n       (arst_n),
		.cyc          (cyc.eng),
		.flash_addr   (flash_addr),
		.flash_dq_out (flash_dq_out),
		.flash_dq_oe  (flash_dq_oe),
		.flash_dq_in  (flash_dq_in),
		.flash_ce_n   (flash_ce_n),
		.flash_we_n   (flash_we_n),
		.flash_oe_n   (flash_oe_n)
	);
endmodule

// ---- fbc_chk.sv ----
/*
 Port checker for the flash bank command controller.
 Assumes one core clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module fbc_chk (
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       flash_ce_n,
	input wire logic       flash_we_n,
	input wire logic       flash_oe_n,
	input wire logic       flash_dq_oe,
	input wire logic       protect_accel_pin
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// Bus answers
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("hresp is not OKAY");
	property p_rd_wait; hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state is not one cycle");
	property p_wr_nowait; hsel && hready && htrans[1] && hwrite |=> hreadyout; endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write was stalled");
	// Flash pin cycles
	property p_we_pulse; $fell(flash_we_n) |-> (flash_dq_oe && !flash_we_n)[*3] ##1 flash_we_n; endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe length wrong");
	property p_ce_hold; $rose(flash_we_n) |-> !flash_ce_n ##1 !flash_ce_n ##1 flash_ce_n; endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("chip enable hold wrong");
	property p_oe_pulse; $fell(flash_oe_n) |-> (!flash_ce_n && !flash_oe_n)[*6] ##1 flash_oe_n; endproperty
	a_oe_pulse: assert property (p_oe_pulse) else $error("read strobe length wrong");
	property p_no_fight; !flash_oe_n |-> !flash_dq_oe && flash_we_n; endproperty
	a_no_fight: assert property (p_no_fight) else $error("data bus driven during read");
	property p_idle; flash_ce_n |-> flash_we_n && flash_oe_n && !flash_dq_oe; endproperty
	a_idle: assert property (p_idle) else $error("strobes active while deselected");
	// Main scenarios seen
	c_read: cover property (hsel && hready && htrans[1] && !hwrite);
	c_write: cover property ($fell(flash_we_n));
	c_accel: cover property ($rose(protect_accel_pin));
endmodule
bind fbc_top fbc_chk fbc_chk_i (.core_clk, .arst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
	.flash_ce_n, .flash_we_n, .flash_oe_n, .flash_dq_oe, .protect_accel_pin);

// ---- fbc_flash_model.sv ----
/*
 Behavioural flash bank answering the controller's pin cycles.
 Assumes the bench resolves the data bus and feeds it to dq_wr.
*/
`timescale 1ns/1ps
module fbc_flash_model #(
	parameter int          ACC_NS   = 60,
	parameter int          PROG_NS  = 2000,
	parameter logic [15:0] MAKER_ID = 16'h0011, // Arbitrary value
	parameter logic [15:0] PART_ID  = 16'h0022  // Arbitrary value
) (
	input wire logic [22:0] flash_addr,
	input wire logic [15:0] dq_wr,
	output logic [15:0]     dq_rd,
	input wire logic        ce_n,
	input wire logic        we_n,
	input wire logic        oe_n,
	input wire logic        accel,
	output logic            ready_busy_n
);
	logic [15:0] mem_r [256];
	logic [1:0]  step_r;
	logic        id_r, sec_r, byp_r, pg_r, ex_r, busy_r, tout_r, tog_r;
	logic [7:0]  ta_r;
	logic [15:0] tv_r, rv, last_r;
	wire         wstb = we_n | ce_n;
	wire         bypass = byp_r | accel;
	// Power-up state reads the array
	initial
	begin
		{step_r, id_r, sec_r, byp_r, pg_r, ex_r, busy_r, tout_r, tog_r} = '0;
		{ta_r, tv_r, last_r} = '0;
		foreach (mem_r[i]) mem_r[i] = 16'hFFFF;
	end
	// Read data source by mode
	always @*
	begin
		if (busy_r) rv = {8'h00, ~tv_r[7], tog_r, tout_r, 5'h00};
		else if (id_r) rv = flash_addr[0] ? PART_ID : MAKER_ID;
		else if (sec_r) rv = 16'h5A00 + 16'(flash_addr[2:0]);
		else rv = mem_r[flash_addr[7:0]];
	end
	// Released bus shows the inverse of the last word
	assign #ACC_NS dq_rd = (!ce_n && !oe_n) ? rv : ~last_r;
	assign ready_busy_n = ~busy_r;
	always @(posedge oe_n) last_r = rv;
	always @(negedge oe_n) if (!ce_n) tog_r = ~tog_r;
	// Command decode on the rising write strobe
	always @(posedge wstb)
	begin
		if (busy_r)
		begin
			if (tout_r && dq_wr == 16'h00F0) {busy_r, tout_r} = 2'b00;
		end
		else if (pg_r)
		begin
			pg_r = 1'b0;
			ta_r = flash_addr[7:0];
			tv_r = dq_wr;
			tout_r = |(dq_wr & ~mem_r[ta_r]);
			mem_r[ta_r] = mem_r[ta_r] & dq_wr;
			busy_r = 1'b1;
			if (!tout_r) fork #PROG_NS busy_r = 1'b0; join_none
		end
		else if (dq_wr == 16'h00F0 && !bypass) {step_r, id_r, ex_r, pg_r} = '0;
		else if (bypass)
		begin
			if (ex_r && dq_wr == 16'h0000) byp_r = 1'b0;
			pg_r = (dq_wr == 16'h00A0);
			ex_r = (dq_wr == 16'h0090);
		end
		else if (step_r == 2'd2)
		begin
			step_r = 2'd0;
			case (dq_wr[7:0])
				8'h90: if (sec_r) ex_r = 1'b1; else id_r = 1'b1;
				8'h88: sec_r = 1'b1;
				8'hA0: pg_r = 1'b1;
				8'h20: byp_r = !sec_r;
				default: step_r = 2'd0;
			endcase
		end
		else if (ex_r && dq_wr == 16'h0000) {sec_r, ex_r} = 2'b00;
		else if (flash_addr[10:0] == 11'h555 && dq_wr == 16'h00AA) step_r = 2'd1;
		else step_r = (step_r == 2'd1 && flash_addr[10:0] == 11'h2AA && dq_wr == 16'h0055) ? 2'd2 : 2'd0;
	end
endmodule

// ---- fbc_tb.sv ----
/*
 Self-checking testbench for the flash bank command controller.
 Assumes the behavioural flash model on the far side of the pins.
*/
`timescale 1ns/1ps
module testbench;
	import fbc_pkg::*;
	localparam logic [15:0] MAKER = 16'h0011; // Arbitrary value
	localparam logic [15:0] PART  = 16'h0022; // Arbitrary value
	localparam logic [7:0]  ID_F  = 8'(1 << ST_ID);
	localparam logic [7:0]  SEC_F = 8'(1 << ST_SEC);
	localparam logic [7:0]  BYP_F = 8'(1 << ST_BYP);
	localparam logic [7:0]  REF_F = 8'(1 << ST_REFU);
	logic          core_clk = 1'b0;
	logic          arst_n = 1'b0;
	logic          hsel = 1'b0;
	logic          hwrite = 1'b0;
	logic [31:0]   haddr = 32'h0;
	logic [31:0]   hwdata = 32'h0;
	logic [1:0]    htrans = 2'h0;
	logic [2:0]    hsize = 3'h2;
	logic [31:0]   hrdata, st, rd;
	logic          hreadyout, hresp, dq_oe, ce_n, we_n, oe_n, rb_n, acc;
	logic [AW-1:0] faddr;
	logic [DW-1:0] dq_out, dq_mod;
	wire [DW-1:0]  dq_in = dq_oe ? dq_out : dq_mod;
	int            err_total = 0;
	int            checks_done = 0;
	always #12.5 core_clk = ~core_clk;
	fbc_top fbc_top_i (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
		.flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .ready_busy_n(rb_n),
		.protect_accel_pin(acc));
	fbc_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) fbc_flash_model_i (.flash_addr(faddr), .dq_wr(dq_in),
		.dq_rd(dq_mod), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .accel(acc), .ready_busy_n(rb_n));
	// Verdict and end of run
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One single AHB transfer, read data left in rd
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Order a command and poll until the controller is idle
	task automatic cmd(input fbc_op_type op, input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, 32'(REG_ADDR), a);
		bus(1'b1, 32'(REG_WDATA), d);
		bus(1'b1, 32'(REG_CMD), 32'(op));
		do bus(1'b0, 32'(REG_STAT), 32'h0); while (rd[ST_BUSY] !== 1'b0);
		st = rd;
	endtask
	task automatic stat(input logic [7:0] e);
		chk("status", {24'h0, e}, {24'h0, st[7:2], 2'b00});
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		cmd(OP_READ, a, 32'h0);
		bus(1'b0, 32'(REG_RDATA), 32'h0);
		chk("rdata", e, rd);
	endtask
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		close_out();
	end
	// Main sequence
	initial
	begin
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		bus(1'b0, 32'(REG_STAT), 32'h0);
		chk("reset status", 32'h00000100, rd);
		bus(1'b1, 32'h00000100, 32'h5);
		bus(1'b0, 32'h00000100, 32'h0);
		chk("unmapped", 32'h0, rd);
		bus(1'b1, 32'(REG_ADDR), 32'hFFFFFFFF);
		bus(1'b0, 32'(REG_ADDR), 32'h0);
		chk("addr reg", 32'h007FFFFF, rd);
		rdchk(32'h10, 32'hFFFF);
		cmd(OP_PROGRAM, 32'h10, 32'h1234); stat(8'h00);
		rdchk(32'h10, 32'h1234);
		cmd(OP_PROGRAM, 32'h10, 32'hFFFF); chk("timeout", 32'h1, 32'(st[ST_TOUT]));
		rdchk(32'h10, 32'h1234);
		cmd(OP_ID_ENTER, 32'h10, 32'h0); stat(ID_F);
		rdchk(32'h0, 32'(MAKER));
		rdchk(32'h1, 32'(PART));
		cmd(OP_PROGRAM, 32'h10, 32'h0); stat(ID_F | REF_F);
		cmd(OP_RESET, 32'h0, 32'h0); stat(8'h00);
		rdchk(32'h10, 32'h1234);
		cmd(OP_SEC_ENTER, 32'h0, 32'h0); stat(SEC_F);
		rdchk(32'h3, 32'h5A03);
		cmd(OP_BYP_ENTER, 32'h0, 32'h0); stat(SEC_F | REF_F);
		bus(1'b1, 32'(REG_CTRL), 32'h1);
		bus(1'b0, 32'(REG_CTRL), 32'h0);
		chk("ctrl reg", 32'h0, rd);
		chk("accel pin", 32'h0, 32'(acc));
		cmd(OP_SEC_EXIT, 32'h0, 32'h0); stat(8'h00);
		rdchk(32'h10, 32'h1234);
		cmd(OP_BYP_ENTER, 32'h0, 32'h0); stat(BYP_F);
		cmd(OP_BYP_PROG, 32'h20, 32'h0A5A); stat(BYP_F);
		cmd(OP_RESET, 32'h0, 32'h0); stat(BYP_F | REF_F);
		cmd(OP_BYP_RESET, 32'h0, 32'h0); stat(8'h00);
		rdchk(32'h20, 32'h0A5A);
		bus(1'b1, 32'(REG_CTRL), 32'h1);
		cmd(OP_BYP_PROG, 32'h30, 32'h00C3); stat(BYP_F);
		chk("accel pin", 32'h1, 32'(acc));
		bus(1'b1, 32'(REG_CTRL), 32'h0);
		rdchk(32'h30, 32'h00C3);
		cmd(fbc_op_type'(4'h9), 32'h0, 32'h0); stat(REF_F);
		close_out();
	end
endmodule
